// ==== hw/bit_sync.sv ====
// bit_sync: two flip-flop synchroniser for a group of asynchronous levels
// assumes: each bit is an independent level; no bus coherence across bits
module bit_sync #(
  parameter int unsigned W = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  // clock and reset
  input logic aclk,
  input logic aresetn,
  // levels
  input logic [W-1:0] d,
  output logic [W-1:0] q
);

  logic [W-1:0] meta_reg;
  logic [W-1:0] sync_reg;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      meta_reg <= RST_VAL;
      sync_reg <= RST_VAL;
    end else begin
      meta_reg <= d;
      sync_reg <= meta_reg;
    end
  end

  assign q = sync_reg;

endmodule

// ==== hw/sensor_pkg.sv ====
// sensor_pkg: types shared by the sensor target design
// assumes: constants come from sensor_regs.svh
package sensor_pkg;

  typedef enum logic [3:0] {
    ST_IDLE, ST_ADDR, ST_ADDR_ACK, ST_RX, ST_RX_ACK, ST_TX, ST_TX_ACK, ST_SKIP
  } bus_st_e;

  typedef struct packed {
    logic [7:0] cfg;
    logic [7:0] rate;
    logic [7:0] int_hi;
    logic [7:0] int_lo;
    logic [7:0] rem_hi;
    logic [7:0] rem_lo;
    logic [7:0] filter;
    logic [5:0] ideality;
    logic [7:0] int_temp;
    logic [7:0] rem_temp;
    logic [7:0] status;
  } sensor_regs_s;

  typedef struct packed {
    bus_st_e st;
    logic scl_d;
    logic sda_d;
    logic [3:0] bitcnt;
    logic [7:0] shreg;
    logic rd;
    logic ara;
    logic [1:0] nbytes;
    logic [7:0] cmd_byte;
    logic [7:0] data_byte;
    logic [7:0] pointer;
    logic sda_oe;
    logic [31:0] idle_cnt;
    logic [31:0] conv_cnt;
    logic oneshot;
    sensor_regs_s regs;
    logic alert;
    logic trip;
    logic [1:0] settle;
    logic [1:0] strap;
    logic awv;
    logic wv;
    logic [7:0] waddr;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [1:0] rresp;
    logic [31:0] rdata;
    logic [15:0] temp_in;
  } core_state_s;

endpackage

// ==== hw/sensor_regs.svh ====
// sensor_regs.svh: offsets, field positions, reset values and timing for the sensor target
// assumes: included by bare name; no logic here, definitions only
`ifndef SENSOR_REGS_SVH
`define SENSOR_REGS_SVH

// register pointer values seen on the two-wire bus
`define R_INT_TEMP 8'h00
`define R_REM_TEMP 8'h01
`define R_STATUS 8'h02
`define R_CFG_RD 8'h03
`define R_RATE_RD 8'h04
`define R_INT_HI_RD 8'h05
`define R_INT_LO_RD 8'h06
`define R_REM_HI_RD 8'h07
`define R_REM_LO_RD 8'h08
`define R_CFG_WR 8'h09
`define R_RATE_WR 8'h0a
`define R_INT_HI_WR 8'h0b
`define R_INT_LO_WR 8'h0c
`define R_REM_HI_WR 8'h0d
`define R_REM_LO_WR 8'h0e
`define R_ONE_SHOT 8'h0f
`define R_FILTER 8'h22
`define R_IDEALITY 8'h27

// reset values
`define RST_CFG 8'h00
`define RST_RATE 8'h08
`define RST_HI_LIM 8'h55
`define RST_LO_LIM 8'h00
`define RST_FILTER 8'h00
`define RST_IDEALITY 6'h12
`define RST_TEMP_IN 16'h0000

// field positions
`define CFG_MASK_BIT 7
`define CFG_STBY_BIT 6
`define FLT_TO_EN_BIT 7
`define ST_REM_LO_BIT 0
`define ST_REM_HI_BIT 1
`define ST_INT_LO_BIT 2
`define ST_INT_HI_BIT 3
`define RATE_MAX 4'h8

// bus addresses: alert response, and the four selectable target addresses (index 0 lowest)
`define ARA_ADDR 7'h0c
`define ADDR_TABLE_DEF {7'h4b, 7'h4a, 7'h49, 7'h48}

// AXI4-Lite side port
`define AXI_TEMP_IN 8'h00
`define AXI_BUS_INFO 8'h04
`define AXI_OKAY 2'b00
`define AXI_SLVERR 2'b10

// timing
`define CLK_HZ 100000000
`define TIMEOUT_MS 25
`define CONV_SLOW_MS 16000
`define SYNC_SETTLE 2'h3

`endif

// ==== hw/smbus_sensor_slave_interface.sv ====
// smbus_sensor_slave_interface: two-wire target, sensor register bank, conversion pacing, AXI4-Lite side port
// assumes: clock and data pins and the address sense arrive asynchronously; front-end samples come over AXI4-Lite
//
// Functional notes
// - acts only as bus target; never starts a transfer
// - serves only write, read, send, receive byte and the alert response query
// - byte write: address, command, data, each acked; data stored at stop
// - byte read: address, command, repeated start, address read, device sends one byte
// - send byte only loads the pointer, no register changes
// - receive byte returns pointed register; pointer stays unchanged
// - alert response query is acked and answered with own target address
// - own address is one of four, picked by sensed address strap
// - foreign address or bad protocol: no ack, registers untouched
// - never holds the clock line low; clock only sampled
// - inactivity timeout enabled only by filter register bit 7, reset zero
// - enabled timeout abandons a transfer after 25 ms of bus silence
// - run mode converts at the programmed rate and updates results
// - standby stops free-running conversions
// - each result is checked against limits; alert flags any fault unless masked, trip flags high-limit faults only
// - 6-bit ideality setting corrects the remote measurement
// - alert response address 0001100 answered only while alert asserted
// - after the query, alert released only if the fault has cleared
// - bus and registers keep working in standby
//
// Added by the designer: register access over AXI4-Lite and the placing of the registers.
`include "sensor_regs.svh"
module smbus_sensor_slave_interface
  import sensor_pkg::*;
#(
  parameter int unsigned TIMEOUT_CYCLES = `TIMEOUT_MS * (`CLK_HZ / 1000),
  parameter int unsigned CONV_SLOW_CYCLES = `CONV_SLOW_MS * (`CLK_HZ / 1000),
  parameter logic [27:0] ADDR_TABLE = `ADDR_TABLE_DEF
) (
  // clock and reset
  input logic aclk,
  input logic aresetn,
  // two-wire bus
  input logic serial_clock_line,
  input logic serial_data_in,
  output logic serial_data_out,
  output logic serial_data_oe,
  // open-drain trip pins and the address strap sense
  output logic alert_or_second_trip_output_out,
  output logic alert_or_second_trip_output_oe,
  output logic address_select_trip_output_out,
  output logic address_select_trip_output_oe,
  input logic [1:0] address_select_sense,
  // front-end controls
  output logic analog_enable,
  output logic [5:0] ideality_setting,
  // AXI4-Lite write
  input logic [7:0] awaddr,
  input logic awvalid,
  output logic awready,
  input logic [31:0] wdata,
  input logic [3:0] wstrb,
  input logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input logic bready,
  // AXI4-Lite read
  input logic [7:0] araddr,
  input logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input logic rready
);

  if (TIMEOUT_CYCLES < 2 || CONV_SLOW_CYCLES < 512) begin : g_bad_param
    $error("timeout or conversion period too short");
  end

  localparam core_state_s CS_RESET = '{
    st: ST_IDLE, scl_d: 1'b1, sda_d: 1'b1, settle: 2'h0,
    regs: '{cfg: `RST_CFG, rate: `RST_RATE, int_hi: `RST_HI_LIM, int_lo: `RST_LO_LIM,
            rem_hi: `RST_HI_LIM, rem_lo: `RST_LO_LIM, filter: `RST_FILTER,
            ideality: `RST_IDEALITY, int_temp: 8'h00, rem_temp: 8'h00, status: 8'h00},
    temp_in: `RST_TEMP_IN, default: '0};

  core_state_s cs_reg;
  core_state_s cs_next;
  logic [3:0] sync_q;
  logic scl_s, sda_s, scl_rise, scl_fall, start_c, stop_c, activity, to_hit, conv_tick, commit;
  logic standby, oor;
  logic [6:0] own_addr;
  logic [31:0] period;
  logic [3:0] shamt;

  //////////////////////////////////////////////////////////////////////////////
  // pin synchronisers; only the second stage is looked at

  bit_sync #(.W(4), .RST_VAL(4'hf)) u_sync (
    .aclk(aclk),
    .aresetn(aresetn),
    .d({serial_clock_line, serial_data_in, address_select_sense}),
    .q(sync_q)
  );

  assign scl_s = sync_q[3];
  assign sda_s = sync_q[2];
  assign scl_rise = scl_s & ~cs_reg.scl_d;
  assign scl_fall = ~scl_s & cs_reg.scl_d;
  // data edges while clock stays high frame the transfer
  assign start_c = scl_s & cs_reg.scl_d & cs_reg.sda_d & ~sda_s;
  assign stop_c = scl_s & cs_reg.scl_d & ~cs_reg.sda_d & sda_s;
  assign activity = (scl_s ^ cs_reg.scl_d) | (sda_s ^ cs_reg.sda_d);
  assign own_addr = ADDR_TABLE[7 * cs_reg.strap +: 7];
  assign standby = cs_reg.regs.cfg[`CFG_STBY_BIT];
  assign oor = |cs_reg.regs.status[3:0];

  assign to_hit = cs_reg.regs.filter[`FLT_TO_EN_BIT] && cs_reg.st != ST_IDLE &&
                  cs_reg.idle_cnt >= TIMEOUT_CYCLES - 1;

  assign shamt = (cs_reg.regs.rate[3:0] > `RATE_MAX || |cs_reg.regs.rate[7:4]) ? `RATE_MAX : cs_reg.regs.rate[3:0];
  assign period = 32'(CONV_SLOW_CYCLES) >> shamt;
  // standby only converts on an explicit one-shot
  assign conv_tick = standby ? cs_reg.oneshot : (cs_reg.conv_cnt >= period - 32'h1);

  assign commit = stop_c && !cs_reg.rd && cs_reg.nbytes == 2'h2 && cs_reg.st != ST_IDLE;

  function automatic logic [7:0] rd_byte(input logic [7:0] ptr, input sensor_regs_s r);
    logic [7:0] v;
    v = 8'h00;
    unique case (ptr)
      `R_INT_TEMP: v = r.int_temp;
      `R_REM_TEMP: v = r.rem_temp;
      `R_STATUS: v = r.status;
      `R_CFG_RD: v = r.cfg;
      `R_RATE_RD: v = r.rate;
      `R_INT_HI_RD: v = r.int_hi;
      `R_INT_LO_RD: v = r.int_lo;
      `R_REM_HI_RD: v = r.rem_hi;
      `R_REM_LO_RD: v = r.rem_lo;
      `R_FILTER: v = r.filter;
      `R_IDEALITY: v = {2'b00, r.ideality};
      default: v = 8'h00;
    endcase
    return v;
  endfunction

  //////////////////////////////////////////////////////////////////////////////
  // next state

  always_comb begin
    logic [6:0] addr;
    logic rw;
    logic [7:0] rem;
    logic [5:0] diff;
    logic [3:0] st_new;
    addr = cs_reg.shreg[7:1];
    rw = cs_reg.shreg[0];
    rem = 8'h00;
    diff = 6'h00;
    st_new = 4'h0;
    cs_next = cs_reg;
    cs_next.scl_d = scl_s;
    cs_next.sda_d = sda_s;
    cs_next.idle_cnt = (activity || cs_reg.st == ST_IDLE) ? 32'h0 : cs_reg.idle_cnt + 32'h1;

    // strap caught once the synchroniser has settled after reset
    if (cs_reg.settle != `SYNC_SETTLE) begin
      cs_next.settle = cs_reg.settle + 2'h1;
      cs_next.strap = sync_q[1:0];
    end

    unique case (cs_reg.st)
      ST_IDLE, ST_SKIP: begin
      end
      ST_ADDR: begin
        if (scl_rise) begin
          cs_next.shreg = {cs_reg.shreg[6:0], sda_s};
          cs_next.bitcnt = cs_reg.bitcnt + 4'h1;
        end else if (scl_fall && cs_reg.bitcnt == 4'h8) begin
          cs_next.bitcnt = 4'h0;
          if (addr == `ARA_ADDR && rw && cs_reg.alert) begin
            cs_next.st = ST_ADDR_ACK;
            cs_next.sda_oe = 1'b1;
            cs_next.rd = 1'b1;
            cs_next.ara = 1'b1;
            cs_next.shreg = {own_addr, 1'b0};
          end else if (addr == own_addr && !(rw && cs_reg.nbytes == 2'h2)) begin
            cs_next.st = ST_ADDR_ACK;
            cs_next.sda_oe = 1'b1;
            cs_next.rd = rw;
            cs_next.ara = 1'b0;
            cs_next.shreg = rd_byte(cs_reg.pointer, cs_reg.regs);
            if (!rw) begin
              cs_next.nbytes = 2'h0;
            end
          end else begin
            cs_next.st = ST_SKIP;
            cs_next.nbytes = 2'h3; // a pending write must not commit at stop
          end
        end
      end
      ST_ADDR_ACK: begin
        if (scl_fall) begin
          if (cs_reg.rd) begin
            cs_next.st = ST_TX;
            cs_next.sda_oe = ~cs_reg.shreg[7];
            cs_next.shreg = {cs_reg.shreg[6:0], 1'b0};
            cs_next.bitcnt = 4'h1;
          end else begin
            cs_next.st = ST_RX;
            cs_next.sda_oe = 1'b0;
          end
        end
      end
      ST_RX: begin
        if (scl_rise) begin
          cs_next.shreg = {cs_reg.shreg[6:0], sda_s};
          cs_next.bitcnt = cs_reg.bitcnt + 4'h1;
        end else if (scl_fall && cs_reg.bitcnt == 4'h8) begin
          cs_next.bitcnt = 4'h0;
          if (cs_reg.nbytes == 2'h2) begin
            cs_next.nbytes = 2'h3; // a third byte is not a supported form
            cs_next.st = ST_SKIP;
          end else begin
            cs_next.nbytes = cs_reg.nbytes + 2'h1;
            cs_next.st = ST_RX_ACK;
            cs_next.sda_oe = 1'b1;
            if (cs_reg.nbytes == 2'h0) begin
              cs_next.cmd_byte = cs_reg.shreg;
              cs_next.pointer = cs_reg.shreg;
            end else begin
              cs_next.data_byte = cs_reg.shreg;
            end
          end
        end
      end
      ST_RX_ACK: begin
        if (scl_fall) begin
          cs_next.st = ST_RX;
          cs_next.sda_oe = 1'b0;
        end
      end
      ST_TX: begin
        if (scl_fall) begin
          if (cs_reg.bitcnt == 4'h8) begin
            cs_next.st = ST_TX_ACK;
            cs_next.sda_oe = 1'b0;
          end else begin
            cs_next.sda_oe = ~cs_reg.shreg[7];
            cs_next.shreg = {cs_reg.shreg[6:0], 1'b0};
            cs_next.bitcnt = cs_reg.bitcnt + 4'h1;
          end
        end
      end
      ST_TX_ACK: begin
        // one byte only; host nack and stop follow
        if (scl_rise) begin
          cs_next.st = ST_SKIP;
          if (cs_reg.ara && !oor) begin
            cs_next.alert = 1'b0;
          end
        end
      end
    endcase

    if (start_c) begin
      cs_next.st = ST_ADDR;
      cs_next.bitcnt = 4'h0;
      cs_next.sda_oe = 1'b0;
      if (cs_reg.st == ST_IDLE || cs_reg.st == ST_SKIP) begin
        cs_next.nbytes = 2'h0;
      end
    end
    if (commit) begin
      unique case (cs_reg.cmd_byte)
        `R_CFG_WR: cs_next.regs.cfg = cs_reg.data_byte;
        `R_RATE_WR: cs_next.regs.rate = cs_reg.data_byte;
        `R_INT_HI_WR: cs_next.regs.int_hi = cs_reg.data_byte;
        `R_INT_LO_WR: cs_next.regs.int_lo = cs_reg.data_byte;
        `R_REM_HI_WR: cs_next.regs.rem_hi = cs_reg.data_byte;
        `R_REM_LO_WR: cs_next.regs.rem_lo = cs_reg.data_byte;
        `R_ONE_SHOT: cs_next.oneshot = standby;
        `R_FILTER: cs_next.regs.filter = cs_reg.data_byte;
        `R_IDEALITY: cs_next.regs.ideality = cs_reg.data_byte[5:0];
        default: begin
        end
      endcase
    end
    if (stop_c || to_hit) begin
      cs_next.st = ST_IDLE;
      cs_next.sda_oe = 1'b0;
      cs_next.nbytes = 2'h0;
      cs_next.rd = 1'b0;
      cs_next.ara = 1'b0;
    end

    // conversion pacing and limit checks
    cs_next.conv_cnt = (standby || conv_tick) ? 32'h0 : cs_reg.conv_cnt + 32'h1;
    if (conv_tick) begin
      cs_next.oneshot = commit && cs_reg.cmd_byte == `R_ONE_SHOT && standby; // a new one-shot wins
      diff = cs_reg.regs.ideality - `RST_IDEALITY;
      rem = cs_reg.temp_in[15:8] + {{2{diff[5]}}, diff};
      cs_next.regs.int_temp = cs_reg.temp_in[7:0];
      cs_next.regs.rem_temp = rem;
      cs_next.regs.status = 8'h00;
      cs_next.regs.status[`ST_REM_LO_BIT] = rem < cs_reg.regs.rem_lo;
      cs_next.regs.status[`ST_REM_HI_BIT] = rem > cs_reg.regs.rem_hi;
      cs_next.regs.status[`ST_INT_LO_BIT] = cs_reg.temp_in[7:0] < cs_reg.regs.int_lo;
      cs_next.regs.status[`ST_INT_HI_BIT] = cs_reg.temp_in[7:0] > cs_reg.regs.int_hi;
      cs_next.trip = cs_next.regs.status[`ST_REM_HI_BIT] | cs_next.regs.status[`ST_INT_HI_BIT];
      // a new fault wins over a release by the alert query
      if (|cs_next.regs.status[3:0] && !cs_reg.regs.cfg[`CFG_MASK_BIT]) begin
        cs_next.alert = 1'b1;
      end
    end

    // AXI4-Lite slave
    if (awvalid && awready) begin
      cs_next.awv = 1'b1;
      cs_next.waddr = awaddr;
    end
    if (wvalid && wready) begin
      cs_next.wv = 1'b1;
      cs_next.wdata = wdata;
      cs_next.wstrb = wstrb;
    end
    if (cs_reg.bvalid && bready) begin
      cs_next.bvalid = 1'b0;
    end
    if (cs_reg.awv && cs_reg.wv) begin
      cs_next.awv = 1'b0;
      cs_next.wv = 1'b0;
      cs_next.bvalid = 1'b1;
      cs_next.bresp = `AXI_OKAY;
      if (cs_reg.waddr == `AXI_TEMP_IN) begin
        if (cs_reg.wstrb[0]) cs_next.temp_in[7:0] = cs_reg.wdata[7:0];
        if (cs_reg.wstrb[1]) cs_next.temp_in[15:8] = cs_reg.wdata[15:8];
      end else if (cs_reg.waddr != `AXI_BUS_INFO) begin
        cs_next.bresp = `AXI_SLVERR;
      end
    end
    if (cs_reg.rvalid && rready) begin
      cs_next.rvalid = 1'b0;
    end
    if (arvalid && arready) begin
      cs_next.rvalid = 1'b1;
      cs_next.rresp = `AXI_OKAY;
      st_new = cs_reg.st;
      unique case (araddr)
        `AXI_TEMP_IN: cs_next.rdata = {16'h0000, cs_reg.temp_in};
        `AXI_BUS_INFO: cs_next.rdata = {cs_reg.alert, cs_reg.trip, standby, cs_reg.regs.filter[`FLT_TO_EN_BIT],
                                        8'h00, st_new, cs_reg.pointer, 1'b0, own_addr};
        default: begin
          cs_next.rdata = 32'h0000_0000;
          cs_next.rresp = `AXI_SLVERR;
        end
      endcase
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cs_reg <= CS_RESET;
    end else begin
      cs_reg <= cs_next;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // outputs

  assign serial_data_out = 1'b0;
  assign serial_data_oe = cs_reg.sda_oe;
  assign alert_or_second_trip_output_out = 1'b0;
  assign alert_or_second_trip_output_oe = cs_reg.alert;
  assign address_select_trip_output_out = 1'b0;
  assign address_select_trip_output_oe = cs_reg.trip;
  assign analog_enable = ~standby;
  assign ideality_setting = cs_reg.regs.ideality;
  assign awready = !cs_reg.awv && !cs_reg.bvalid;
  assign wready = !cs_reg.wv && !cs_reg.bvalid;
  assign bvalid = cs_reg.bvalid;
  assign bresp = cs_reg.bresp;
  assign arready = !cs_reg.rvalid;
  assign rvalid = cs_reg.rvalid;
  assign rresp = cs_reg.rresp;
  assign rdata = cs_reg.rdata;

  //////////////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  AST_IDLE_QUIET: assert property (cs_reg.st == ST_IDLE |-> !serial_data_oe)
    else $error("data line driven while idle");
  AST_FOREIGN_SILENT: assert property (cs_reg.st == ST_SKIP |-> !serial_data_oe)
    else $error("data line driven in skipped transfer");
  AST_TIMEOUT_IDLE: assert property (to_hit && !start_c |=> cs_reg.st == ST_IDLE && !serial_data_oe)
    else $error("timeout did not return to idle");
  AST_TIMEOUT_OFF: assert property (!cs_reg.regs.filter[`FLT_TO_EN_BIT] && cs_reg.st != ST_IDLE && !stop_c
                                    |=> cs_reg.st != ST_IDLE)
    else $error("timeout fired while disabled");
  AST_SEND_KEEPS: assert property (stop_c && cs_reg.nbytes == 2'h1 && !conv_tick |=> $stable(cs_reg.regs))
    else $error("send byte changed a register");
  AST_ARA_NEEDS_ALERT: assert property ($rose(cs_reg.ara) |-> $past(cs_reg.alert) && serial_data_oe)
    else $error("alert query acked without alert");
  AST_RECV_PTR: assert property (cs_reg.st == ST_TX |=> $stable(cs_reg.pointer))
    else $error("pointer moved during receive");
  AST_STANDBY_HOLD: assert property (standby && !cs_reg.oneshot |-> !conv_tick ##1 cs_reg.conv_cnt == 32'h0)
    else $error("conversion while in standby");
  AST_RUN_PERIOD: assert property (!standby && $stable(cs_reg.regs.rate) |-> cs_reg.conv_cnt < period)
    else $error("conversion period overrun");
  AST_ALERT_RELEASE: assert property (cs_reg.st == ST_TX_ACK && cs_reg.ara && scl_rise
                                      && !oor && !conv_tick |=> !alert_or_second_trip_output_oe)
    else $error("alert kept after cleared fault");

endmodule

// ==== tb/smbus_host_model.sv ====
// smbus_host_model: behavioural two-wire bus host, open drain on the data line, clock driven directly
// assumes: sda is the resolved wire with a pull-up; bench calls the transaction tasks
module smbus_host_model (
  // bus wires
  input wire logic sda,
  output logic scl,
  output logic sda_low
);
  timeunit 1ns;
  timeprecision 1ps;
  // quarter of a 125 ns bus clock; clock stands high between frames
  localparam realtime Q = 31.25;
  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
  end
  //////////////////////////////////////////////////////////////////////////////
  task automatic start();
    #Q sda_low = 1'b0;
    #Q scl = 1'b1;
    #Q sda_low = 1'b1;
    #Q scl = 1'b0;
  endtask
  task automatic stop();
    #Q sda_low = 1'b1;
    #Q scl = 1'b1;
    #Q sda_low = 1'b0;
    #Q;
  endtask
  task automatic clk_bit(input logic b, output logic s);
    #Q sda_low = !b;
    #Q scl = 1'b1;
    #Q s = sda;
    #Q scl = 1'b0;
  endtask
  task automatic put(input logic [7:0] d, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) clk_bit(d[i], s);
    clk_bit(1'b1, s);
    ack = !s;
  endtask
  task automatic get(output logic [7:0] d);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      clk_bit(1'b1, s);
      d[i] = s;
    end
    clk_bit(1'b1, s);
  endtask
  //////////////////////////////////////////////////////////////////////////////
  // data writes go only through the full write transaction
  task automatic write_byte(input logic [6:0] a, input logic [7:0] c, input logic [7:0] d,
                            output logic [2:0] k);
    start();
    put({a, 1'b0}, k[2]);
    put(c, k[1]);
    put(d, k[0]);
    stop();
  endtask
  task automatic read_byte(input logic [6:0] a, input logic [7:0] c, output logic [7:0] d,
                           output logic [2:0] k);
    start();
    put({a, 1'b0}, k[2]);
    put(c, k[1]);
    start();
    put({a, 1'b1}, k[0]);
    get(d);
    stop();
  endtask
  task automatic send_byte(input logic [6:0] a, input logic [7:0] c, output logic [1:0] k);
    start();
    put({a, 1'b0}, k[1]);
    put(c, k[0]);
    stop();
  endtask
  // also the alert query when called with the response address
  task automatic recv_byte(input logic [6:0] a, output logic [7:0] d, output logic k);
    start();
    put({a, 1'b1}, k);
    get(d);
    stop();
  endtask
endmodule

// ==== tb/smbus_sensor_slave_interface_bench.sv ====
// smbus_sensor_slave_interface_bench: register bus tasks and bus transactions with expected values
// assumes: strap tied to index 0; short timeout and conversion counts set below
`include "sensor_regs.svh"
module smbus_sensor_slave_interface_bench;
  timeunit 1ns;
  timeprecision 1ps;
  import sensor_pkg::*;
  logic aclk = 1'b0;
  logic aresetn, awvalid, wvalid, bready, arvalid, rready, scl, sda_low;
  logic awready, wready, bvalid, arready, rvalid, sda_oe, alert_oe, trip_oe, an_en;
  logic [7:0] awaddr, araddr, b;
  logic [31:0] wdata, rdata, v;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp, r, k2;
  logic [5:0] ideal;
  logic [2:0] k3, outs;
  logic k1;
  int errors = 0;
  int checked = 0;
  wire sda = !(sda_low || sda_oe);
  always #5 aclk = !aclk;
  smbus_sensor_slave_interface #(.TIMEOUT_CYCLES(200), .CONV_SLOW_CYCLES(2048)) smbus_sensor_slave_interface_inst (
    .aclk(aclk), .aresetn(aresetn), .serial_clock_line(scl), .serial_data_in(sda), .serial_data_out(outs[2]),
    .serial_data_oe(sda_oe), .alert_or_second_trip_output_out(outs[1]), .alert_or_second_trip_output_oe(alert_oe),
    .address_select_trip_output_out(outs[0]), .address_select_trip_output_oe(trip_oe), .address_select_sense(2'b00),
    .analog_enable(an_en), .ideality_setting(ideal), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
    .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
    .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
    .rvalid(rvalid), .rready(rready));
  smbus_host_model smbus_host_model_inst (.sda(sda), .scl(scl), .sda_low(sda_low));
  //////////////////////////////////////////////////////////////////////////////
  task automatic test_done();
    $display("checks %0d mismatches %0d", checked, errors);
    if (errors == 0 && checked > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
    checked++;
    if (seen !== exp) begin
      errors++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // handshakes decided mid-cycle, acted on at the next rising edge
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] rs);
    logic at, wt, bt;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (int n = 0; n < 100; n++) begin
      @(negedge aclk);
      at = awvalid && awready;
      wt = wvalid && wready;
      bt = bvalid && bready;
      rs = bresp;
      @(posedge aclk);
      if (at) awvalid <= 1'b0;
      if (wt) wvalid <= 1'b0;
      if (bt) begin
        bready <= 1'b0;
        return;
      end
    end
    errors++;
    test_done();
  endtask
  task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] rs);
    logic at, rt;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (int n = 0; n < 100; n++) begin
      @(negedge aclk);
      at = arvalid && arready;
      rt = rvalid && rready;
      d = rdata;
      rs = rresp;
      @(posedge aclk);
      if (at) arvalid <= 1'b0;
      if (rt) begin
        rready <= 1'b0;
        return;
      end
    end
    errors++;
    test_done();
  endtask
  //////////////////////////////////////////////////////////////////////////////
  initial begin
    #1ms;
    errors++;
    test_done();
  end
  initial begin
    {aresetn, awvalid, wvalid, bready, arvalid, rready, awaddr, araddr, wdata} = '0;
    wstrb = 4'hf;
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (8) @(posedge aclk);
    axi_rd(`AXI_BUS_INFO, v, r);
    chk(v, {16'h0000, 8'h00, 8'h48}, "reset info");
    chk(ideal, `RST_IDEALITY, "reset ideality");
    chk({r, outs}, {`AXI_OKAY, 3'b000}, "read resp and pin values");
    $display("test reset done");
    smbus_host_model_inst.write_byte(7'h48, `R_INT_HI_WR, 8'h30, k3);
    chk(k3, 3'b111, "write acks");
    smbus_host_model_inst.read_byte(7'h48, `R_INT_HI_RD, b, k3);
    chk({k3, b}, {3'b111, 8'h30}, "read byte");
    smbus_host_model_inst.recv_byte(7'h48, b, k1);
    chk(b, 8'h30, "pointer from command");
    smbus_host_model_inst.send_byte(7'h48, `R_RATE_RD, k2);
    for (int i = 0; i < 2; i++) begin
      smbus_host_model_inst.recv_byte(7'h48, b, k1);
      chk({k2, k1, b}, {3'b111, `RST_RATE}, "receive");
    end
    axi_rd(`AXI_BUS_INFO, v, r);
    chk(v[15:8], `R_RATE_RD, "pointer");
    $display("test pointer done");
    smbus_host_model_inst.write_byte(7'h50, `R_INT_HI_WR, 8'h99, k3);
    chk(k3, 3'b000, "foreign acks");
    smbus_host_model_inst.start();
    smbus_host_model_inst.put(8'h90, k1);
    smbus_host_model_inst.put(`R_INT_HI_WR, k1);
    smbus_host_model_inst.put(8'h66, k1);
    smbus_host_model_inst.put(8'h67, k1);
    smbus_host_model_inst.stop();
    chk(k1, 1'b0, "third byte refused");
    smbus_host_model_inst.read_byte(7'h48, `R_INT_HI_RD, b, k3);
    chk(b, 8'h30, "untouched");
    smbus_host_model_inst.recv_byte(`ARA_ADDR, b, k1);
    chk(k1, 1'b0, "query while quiet");
    axi_wr(`AXI_TEMP_IN, 32'h40, r);
    repeat (40) @(posedge aclk);
    chk({r, alert_oe, trip_oe}, {`AXI_OKAY, 2'b11}, "fault outputs");
    smbus_host_model_inst.recv_byte(`ARA_ADDR, b, k1);
    chk({k1, b}, {1'b1, 8'h90}, "query answer");
    chk(alert_oe, 1'b1, "alert persists");
    axi_wr(`AXI_TEMP_IN, 32'h10, r);
    repeat (40) @(posedge aclk);
    chk(trip_oe, 1'b0, "fault gone");
    smbus_host_model_inst.recv_byte(`ARA_ADDR, b, k1);
    chk(alert_oe, 1'b0, "alert released");
    $display("test alert done");
    smbus_host_model_inst.write_byte(7'h48, `R_CFG_WR, 8'h40, k3);
    chk(an_en, 1'b0, "standby");
    axi_wr(`AXI_TEMP_IN, 32'h40, r);
    repeat (40) @(posedge aclk);
    chk(trip_oe, 1'b0, "no conversion");
    smbus_host_model_inst.read_byte(7'h48, `R_CFG_RD, b, k3);
    chk(b, 8'h40, "bus in standby");
    smbus_host_model_inst.write_byte(7'h48, `R_ONE_SHOT, 8'h00, k3);
    repeat (20) @(posedge aclk);
    chk(trip_oe, 1'b1, "one shot");
    smbus_host_model_inst.write_byte(7'h48, `R_IDEALITY, 8'h13, k3);
    chk(ideal, 6'h13, "ideality");
    $display("test standby done");
    for (int e = 0; e < 2; e++) begin
      smbus_host_model_inst.start();
      smbus_host_model_inst.put({7'h48, 1'b0}, k1);
      repeat (300) @(posedge aclk);
      axi_rd(`AXI_BUS_INFO, v, r);
      chk({v[28], v[19:16], sda_oe}, e ? 6'h20 : 6'h06, "stalled bus");
      smbus_host_model_inst.stop();
      smbus_host_model_inst.write_byte(7'h48, `R_FILTER, 8'h80, k3);
    end
    $display("test timeout done");
    axi_rd(8'h08, v, r);
    chk({r, v[29:0]}, {`AXI_SLVERR, 30'h0}, "unmapped read");
    axi_wr(8'h0c, 32'h1, r);
    chk(r, `AXI_SLVERR, "unmapped write");
    $display("test register bus done");
    test_done();
  end
endmodule
